// >>> verilog/spc_pkg.sv
// Constants, register map and state types of the presettable counter pair.
// Assumes one 100 MHz clock pclk and an APB master on the controller side.
// Functional notes
// - Low clear forces count outputs low asynchronously
// - Low load copies presets on next edge
// - Parallel and trickle enables are ANDed internally
// - Decade preset 10-15 rejoins sequence, never above nine
// - Cascade: parallel enables from first stage flag
// - Cascade: second stage trickle enable held high
// - Enables fall only while clock is high
// - Load enable rises only while clock is high
// - Decade wraps nine to zero, binary fifteen
// - Flag high: trickle high and maximum state
// - Precedence: clear, load, count, hold
// - Count outputs change only on rising clock edge, except low clear; flag also follows trickle
package spc_pkg;
	localparam int unsigned SPC_CNT_W = 4;
	localparam logic [SPC_CNT_W-1:0] SPC_MAX_DECADE = 4'h9;
	localparam logic [SPC_CNT_W-1:0] SPC_MAX_BINARY = 4'hf;
	localparam logic [SPC_CNT_W-1:0] SPC_CNT_RESET = 4'h0;
	// Illegal decade states drop by this amount, landing on 2..7
	localparam logic [SPC_CNT_W-1:0] SPC_ILLEGAL_DROP = 4'h8;
	localparam logic [31:0] SPC_ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] SPC_ADDR_LOAD = 32'h0000_0004;
	localparam logic [31:0] SPC_ADDR_STATUS = 32'h0000_0008;
	localparam logic [31:0] SPC_ADDR_DIV = 32'h0000_000c;
	localparam int unsigned SPC_CTRL_PAR_BIT = 0;
	localparam int unsigned SPC_CTRL_TRK_BIT = 1;
	localparam int unsigned SPC_CTRL_CLR_BIT = 2;
	localparam int unsigned SPC_STAT_TC_BIT = 4;
	localparam logic [2:0] SPC_CTRL_RESET = 3'h4;
	localparam logic [15:0] SPC_DIV_RESET = 16'h0000;
	localparam logic [SPC_CNT_W-1:0] SPC_PRESET_RESET = 4'h0;
	typedef struct packed {
		logic [SPC_CNT_W-1:0] count;
	} spc_dev_state_t;
	typedef struct packed {
		logic [2:0] ctrl;
		logic [15:0] div;
		logic [15:0] div_cnt;
		logic [SPC_CNT_W-1:0] preset;
		logic load_n;
		logic tick;
		logic [31:0] prdata;
		logic pslverr;
	} spc_ctl_state_t;
endpackage

// >>> verilog/spc_if.sv
// Link between the counter stage and its controlling logic.
// Assumes both ends run on the same pclk; the bench instantiates it.
`timescale 1ns/1ps
interface spc_if;
	logic async_clear_n;
	logic load_enable_n;
	logic count_enable_parallel;
	logic count_enable_trickle;
	logic [spc_pkg::SPC_CNT_W-1:0] preset_inputs;
	logic [spc_pkg::SPC_CNT_W-1:0] count_outputs;
	logic terminal_count_flag;
	modport dev (
		input async_clear_n,
		input load_enable_n,
		input count_enable_parallel,
		input count_enable_trickle,
		input preset_inputs,
		output count_outputs,
		output terminal_count_flag
	);
	modport ctl (
		output async_clear_n,
		output load_enable_n,
		output count_enable_parallel,
		output count_enable_trickle,
		output preset_inputs,
		input count_outputs,
		input terminal_count_flag
	);
endinterface // spc_if

// >>> verilog/spc_counter.sv
// Four-bit synchronous presettable up-counter, decade or binary build.
// Assumes pclk is the count clock and the controller keeps the drive rules.
`timescale 1ns/1ps
module spc_counter #(
	parameter bit DECADE = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	spc_if.dev lnk
);
	localparam logic [spc_pkg::SPC_CNT_W-1:0] MAX =
		DECADE ? spc_pkg::SPC_MAX_DECADE : spc_pkg::SPC_MAX_BINARY;
	spc_pkg::spc_dev_state_t s_q;
	spc_pkg::spc_dev_state_t s_d;
	logic clr_n;
	logic cnt_en;
	// Clear acts without the clock; system reset joins it
	assign clr_n = presetn & lnk.async_clear_n;
	assign cnt_en = lnk.count_enable_parallel & lnk.count_enable_trickle;
	always_comb
	begin
		s_d = s_q;
		if (!lnk.load_enable_n)
		begin
			s_d.count = lnk.preset_inputs;
		end
		else if (cnt_en)
		begin
			if (s_q.count == MAX)
			begin
				s_d.count = spc_pkg::SPC_CNT_RESET;
			end
			else if (s_q.count > MAX)
			begin
				// Illegal decade state falls back into 2..7 in one edge
				s_d.count = s_q.count - spc_pkg::SPC_ILLEGAL_DROP;
			end
			else
			begin
				s_d.count = s_q.count + 4'h1;
			end
		end
		// Otherwise hold
	end
	always_ff @(posedge pclk or negedge clr_n)
	begin
		if (!clr_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end
	assign lnk.count_outputs = s_q.count;
	// Decoded full state; may glitch, so never use it as a clock
	assign lnk.terminal_count_flag = lnk.count_enable_trickle & (s_q.count == MAX);
endmodule // spc_counter

// >>> verilog/spc_ctrl.sv
// Controller driving one counter stage, with an APB register slave.
// Assumes an APB master on pclk; the counter sits on the ctl modport.
`timescale 1ns/1ps
module spc_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	spc_if.ctl lnk
);
	spc_pkg::spc_ctl_state_t s_q;
	spc_pkg::spc_ctl_state_t s_d;
	logic setup;
	logic wr;
	logic hit;
	function automatic logic addr_ok(input logic [31:0] a);
		addr_ok = (a == spc_pkg::SPC_ADDR_CTRL) || (a == spc_pkg::SPC_ADDR_LOAD) ||
			(a == spc_pkg::SPC_ADDR_STATUS) || (a == spc_pkg::SPC_ADDR_DIV);
	endfunction
	assign setup = psel & ~penable;
	assign hit = addr_ok(paddr);
	assign wr = psel & penable & pwrite & hit;
	always_comb
	begin
		s_d = s_q;
		// Load pulse lasts one cycle; it rises right after an edge
		s_d.load_n = 1'b1;
		// Prescaler: one-cycle enable pulse every div+1 cycles
		if (s_q.div_cnt >= s_q.div)
		begin
			s_d.div_cnt = 16'h0000;
			s_d.tick = 1'b1;
		end
		else
		begin
			s_d.div_cnt = s_q.div_cnt + 16'h0001;
			s_d.tick = 1'b0;
		end
		if (setup)
		begin
			// Read data and error are captured in setup for the zero-wait access
			s_d.pslverr = ~hit;
			s_d.prdata = 32'h0000_0000;
			if (paddr == spc_pkg::SPC_ADDR_CTRL)
			begin
				s_d.prdata[2:0] = s_q.ctrl;
			end
			else if (paddr == spc_pkg::SPC_ADDR_LOAD)
			begin
				s_d.prdata[spc_pkg::SPC_CNT_W-1:0] = s_q.preset;
			end
			else if (paddr == spc_pkg::SPC_ADDR_STATUS)
			begin
				s_d.prdata[spc_pkg::SPC_CNT_W-1:0] = lnk.count_outputs;
				s_d.prdata[spc_pkg::SPC_STAT_TC_BIT] = lnk.terminal_count_flag;
			end
			else if (paddr == spc_pkg::SPC_ADDR_DIV)
			begin
				s_d.prdata[15:0] = s_q.div;
			end
		end
		if (wr)
		begin
			if (paddr == spc_pkg::SPC_ADDR_CTRL)
			begin
				s_d.ctrl = pwdata[2:0];
			end
			else if (paddr == spc_pkg::SPC_ADDR_LOAD)
			begin
				s_d.preset = pwdata[spc_pkg::SPC_CNT_W-1:0];
				s_d.load_n = 1'b0;
			end
			else if (paddr == spc_pkg::SPC_ADDR_DIV)
			begin
				s_d.div = pwdata[15:0];
				s_d.div_cnt = 16'h0000;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q.ctrl <= spc_pkg::SPC_CTRL_RESET;
			s_q.div <= spc_pkg::SPC_DIV_RESET;
			s_q.div_cnt <= 16'h0000;
			s_q.preset <= spc_pkg::SPC_PRESET_RESET;
			s_q.load_n <= 1'b1;
			s_q.tick <= 1'b0;
			s_q.prdata <= 32'h0000_0000;
			s_q.pslverr <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end
	assign pready = 1'b1;
	assign prdata = s_q.prdata;
	assign pslverr = psel & penable & s_q.pslverr;
	assign lnk.async_clear_n = ~s_q.ctrl[spc_pkg::SPC_CTRL_CLR_BIT];
	assign lnk.load_enable_n = s_q.load_n;
	// All enables are flop outputs, so they change just after the rising edge
	assign lnk.count_enable_parallel = s_q.ctrl[spc_pkg::SPC_CTRL_PAR_BIT] & s_q.tick;
	// A single stage has no upstream flag, so trickle is a held level
	assign lnk.count_enable_trickle = s_q.ctrl[spc_pkg::SPC_CTRL_TRK_BIT];
	assign lnk.preset_inputs = s_q.preset;
endmodule // spc_ctrl

// >>> tb/spc_properties.sv
// Link properties of one decade counter stage and its controller.
// Assumes pclk, presetn and the link signals are wired by name.
`timescale 1ns/1ps
module spc_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_clear_n,
	input wire logic load_enable_n,
	input wire logic count_enable_parallel,
	input wire logic count_enable_trickle,
	input wire logic [3:0] preset_inputs,
	input wire logic [3:0] count_outputs,
	input wire logic terminal_count_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic [3:0] c = count_outputs;
	wire logic e = count_enable_parallel && count_enable_trickle;
	wire logic r = async_clear_n && load_enable_n;
	clear_low_a: assert property (!async_clear_n |-> c == 4'h0) else $error("clear");
	load_copy_a: assert property (async_clear_n && !load_enable_n ##1 async_clear_n |->
		c == $past(preset_inputs)) else $error("load");
	hold_a: assert property (r && !e ##1 async_clear_n |-> $stable(c)) else $error("hold");
	count_up_a: assert property (r && e && c < 4'h9 |=> !async_clear_n ||
		c == $past(c) + 4'h1) else $error("count");
	wrap_nine_a: assert property (r && e && c == 4'h9 |=> !async_clear_n || c == 4'h0)
		else $error("wrap");
	illegal_exit_a: assert property (r && e && c > 4'h9 |=> !async_clear_n ||
		c == $past(c) - 4'h8) else $error("illegal");
	flag_decode_a: assert property (terminal_count_flag == (count_enable_trickle && c == 4'h9))
		else $error("flag");
	load_pulse_a: assert property (!load_enable_n |=> load_enable_n) else $error("pulse");
	cover property (r && e && c == 4'h9);
	cover property (!load_enable_n && preset_inputs > 4'h9);
	cover property (r && e && c > 4'h9);
endmodule // spc_properties

// >>> tb/tb_top.sv
// Random bench for the decade counter stage under its APB controller.
// Assumes pready within 20 access edges; model follows the link.
`timescale 1ns/1ps
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er;
	logic [3:0] ex = 4'h0;
	logic [3:0] exb = 4'h0;
	logic [3:0] p;
	logic [2:0] c;
	int num_errors = 0, num_checks = 0, seed;
	spc_if la();
	spc_ctrl u_spc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(la.ctl));
	spc_counter #(.DECADE(1'b1)) u_spc_counter (.pclk(pclk), .presetn(presetn), .lnk(la.dev));
	// Binary build shadows the decade stage on the same controls, so both wraps are seen
	spc_if lb();
	spc_counter #(.DECADE(1'b0)) u_spc_counter_bin (.pclk(pclk), .presetn(presetn),
		.lnk(lb.dev));
	assign lb.async_clear_n = la.async_clear_n;
	assign lb.load_enable_n = la.load_enable_n;
	assign lb.count_enable_parallel = la.count_enable_parallel;
	assign lb.count_enable_trickle = la.count_enable_trickle;
	assign lb.preset_inputs = la.preset_inputs;
	spc_properties u_spc_properties (.pclk(pclk), .presetn(presetn),
		.async_clear_n(la.async_clear_n), .load_enable_n(la.load_enable_n),
		.count_enable_parallel(la.count_enable_parallel),
		.count_enable_trickle(la.count_enable_trickle), .preset_inputs(la.preset_inputs),
		.count_outputs(la.count_outputs), .terminal_count_flag(la.terminal_count_flag));
	always #5 pclk = ~pclk;
	// Next count of a stage whose top state is mx
	function automatic logic [3:0] next_count(logic [3:0] v, logic [3:0] mx);
		if (v == mx)
			return 4'h0;
		if (v > mx)
			return v - 4'h8;
		return v + 4'h1;
	endfunction
	// Reference step of both stages, seen from the link signals
	always @(posedge pclk)
	begin
		if (!la.async_clear_n)
		begin
			ex <= 4'h0;
			exb <= 4'h0;
		end
		else if (!la.load_enable_n)
		begin
			ex <= la.preset_inputs;
			exb <= la.preset_inputs;
		end
		else if (la.count_enable_parallel && la.count_enable_trickle)
		begin
			ex <= next_count(ex, 4'h9);
			exb <= next_count(exb, 4'hf);
		end
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(logic [31:0] g, logic [31:0] x);
		num_checks++;
		if (g !== x)
		begin
			num_errors++;
			$display("Error at %0t: got %h exp %h", $time, g, x);
		end
	endtask
	// Pready is waited for, never assumed; a hang ends the run
	task automatic xfer(logic [31:0] a, logic [31:0] w, logic wr);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= w;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Only a wait that never saw pready counts as a hang
		if (pready !== 1'b1)
		begin
			num_errors++;
			end_sim();
		end
	endtask
	initial
	begin
		seed = $urandom(53251);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		xfer(32'h0000_0008, 32'h0000_0000, 1'b0);
		chk(rd, 32'h0000_0000);
		xfer(32'h0000_0000, 32'h0000_0000, 1'b1);
		for (int i = 0; i < 30; i++)
		begin
			p = i < 3 ? 4'h9 + 4'(i * 3) : 4'($urandom);
			c = i < 3 ? 3'h3 : 3'($urandom);
			xfer(32'h0000_0004, {28'h0, p}, 1'b1);
			xfer(32'h0000_000c, 32'($urandom_range(3)), 1'b1);
			xfer(32'h0000_0000, {29'h0, c}, 1'b1);
			repeat ($urandom_range(12)) @(posedge pclk);
			xfer(32'h0000_0000, {29'h0, c & 3'h6}, 1'b1);
			repeat (4) @(posedge pclk);
			xfer(32'h0000_0008, 32'h0000_0000, 1'b0);
			chk(rd & 32'h1f, {27'h0, c[1] && ex == 4'h9, ex});
			chk({27'h0, lb.terminal_count_flag, lb.count_outputs}, {27'h0, c[1] && exb == 4'hf, exb});
			$display("test %0d done", i);
		end
		xfer(32'h0000_0010, 32'h0000_00ff, 1'b1);
		chk({31'h0, er}, 32'h0000_0001);
		end_sim();
	end
endmodule // tb_top
